// File: src/pws_consts.svh
/*
 Timing figures and widths for the wiper stepper.
 Assumes a 25 MHz core clock; counts are derived from the figures below.
*/
`ifndef PWS_CONSTS_SVH
`define PWS_CONSTS_SVH

`define PWS_CLK_MHZ 25
`define PWS_POS_W 6
`define PWS_POS_MAX 6'h3F
`define PWS_POS_MIN 6'h00
`define PWS_POS_RST 6'h00
`define PWS_NV_BIT 3
`define PWS_T_CONTACT_US 1000
`define PWS_T_DIGITAL_US 1
`define PWS_T_HOLD_MS 1000
`define PWS_T_REPEAT_MS 100
`define PWS_T_IDLE_MS 1000
`define PWS_T_NV_MS 2000
`define PWS_DEB_W 15
`define PWS_TMR_W 27

`endif

// File: src/pws_pkg.sv
/*
 Types shared by the wiper stepper.
 Assumes pws_consts.svh is on the include path.
*/
package pws_pkg;
  typedef enum logic [0:0] {
    PWS_MODE_DUAL = 1'b0,
    PWS_MODE_SINGLE = 1'b1
  } pws_mode_t;

  typedef enum logic [1:0] {
    PWS_CH_UP = 2'b00,
    PWS_CH_DOWN = 2'b01,
    PWS_CH_PROC = 2'b10
  } pws_chan_t;
endpackage

// File: src/pws_stepper.sv
/*
 Pulse width driven wiper position stepper with nonvolatile save requests.
 Three active-low inputs are filtered, turned into steps and auto-repeats,
 and the position is scheduled for saving in a nonvolatile store.
 Assumes all inputs synchronous to clk_i; the store supplies its saved position
 on nv_pos_i at reset release and accepts a one-cycle write strobe.
 Assumes the mode strap pin is settled before reset is released.
*/
// What this block does
// - Hold a wiper position selecting one of 64 uniform taps.
// - All three control inputs are active low.
// - A falling edge on any input starts a pulse, except on the down input in single mode.
// - Each recognised single pulse moves the wiper exactly one step, or none when it steps toward the end it is at.
// - Gaps under 1 ms high (1 us on the processor input) merge pulses into one.
// - Held beyond 1 s, step again every 100 ms until release.
// - Single mode uses up input both ways; down input ignored.
// - Single mode only when down input tied to supply at power-up.
// - Dual mode when down input floats at power-up.
// - Single mode first move after a pause opposes previous direction.
// - Single mode reverses after over 1 s idle or at range end.
// - Processor input steps single-style in every mode, faster rate.
// - Dual mode: up input moves up, down input moves down, no wait.
// - Dual mode stops at range ends without reversing.
// - Up and down button inputs are debounced internally.
// - Position kept in nonvolatile store across power loss.
// - Save 2 s after a change; first change after power-up always saved.
// - Later saves only when position bit 3 changes.
// - Timing thresholds may be off by fifteen percent.
`timescale 1ns/1ns
`include "pws_consts.svh"

module pws_stepper #(
  parameter int T_CONTACT_CYC = `PWS_T_CONTACT_US * `PWS_CLK_MHZ,
  parameter int T_HOLD_CYC = `PWS_T_HOLD_MS * 1000 * `PWS_CLK_MHZ,
  parameter int T_REPEAT_CYC = `PWS_T_REPEAT_MS * 1000 * `PWS_CLK_MHZ,
  parameter int T_IDLE_CYC = `PWS_T_IDLE_MS * 1000 * `PWS_CLK_MHZ,
  parameter int T_NV_CYC = `PWS_T_NV_MS * 1000 * `PWS_CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic up_button_input_n_i,
  input wire logic down_button_input_n_i,
  input wire logic proc_pulse_n_i,
  input wire logic down_tied_supply_i,
  input wire logic [`PWS_POS_W-1:0] nv_pos_i,
  output logic [`PWS_POS_W-1:0] wiper_pos_o,
  output logic nv_write_o,
  output logic [`PWS_POS_W-1:0] nv_data_o,
  output logic mode_single_o,
  output logic dir_up_o
);
  localparam int T_DIGITAL_CYC = `PWS_T_DIGITAL_US * `PWS_CLK_MHZ;

  function automatic logic [`PWS_DEB_W-1:0] deb_limit(input int ch);
    if (ch == int'(pws_pkg::PWS_CH_PROC)) begin
      return `PWS_DEB_W'(T_DIGITAL_CYC - 1);
    end else begin
      return `PWS_DEB_W'(T_CONTACT_CYC - 1);
    end
  endfunction

  function automatic logic hits_end(input logic [`PWS_POS_W-1:0] p, input logic up);
    if (up) begin
      return p == `PWS_POS_MAX;
    end else begin
      return p == `PWS_POS_MIN;
    end
  endfunction

  function automatic logic [`PWS_POS_W-1:0] sat_step(input logic [`PWS_POS_W-1:0] p,
                                                    input logic up);
    if (hits_end(p, up)) begin
      return p;
    end else if (up) begin
      return p + `PWS_POS_W'(1);
    end else begin
      return p - `PWS_POS_W'(1);
    end
  endfunction

  // Filters and edges
  logic [2:0] raw_n;
  logic [2:0] filt_n;
  logic [2:0] filt_q;
  logic [`PWS_DEB_W-1:0] deb_cnt [3];
  logic [2:0] chan_en;
  logic [2:0] fall;
  logic loaded;
  // Stepping
  logic hold_act;
  pws_pkg::pws_chan_t hold_ch;
  logic [`PWS_TMR_W-1:0] hold_cnt;
  logic rep_fire;
  logic step_go;
  pws_pkg::pws_chan_t step_ch;
  logic sstyle;
  logic eff_up;
  logic [`PWS_POS_W-1:0] next_pos;
  // Direction
  logic rev_pend;
  logic end_flip;
  logic [`PWS_TMR_W-1:0] idle_cnt;
  logic idle_done;
  logic sactive;
  // Saving
  logic first_done;
  logic nv_pend;
  logic [`PWS_TMR_W-1:0] nv_cnt;
  logic [`PWS_POS_W-1:0] stored;
  logic nv_arm;
  logic nv_fire;

  assign raw_n = {proc_pulse_n_i, down_button_input_n_i, up_button_input_n_i};

  // Previous filtered level for edge detection
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      filt_q <= 3'h7;
    end else begin
      filt_q <= filt_n;
    end
  end

  // Input filters: level follows only after a stable run
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      filt_n <= 3'h7;
      for (int i = 0; i < 3; i++) begin
        deb_cnt[i] <= `PWS_DEB_W'h0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (raw_n[i] == filt_n[i]) begin
          deb_cnt[i] <= `PWS_DEB_W'h0;
        end else if (deb_cnt[i] >= deb_limit(i)) begin
          filt_n[i] <= raw_n[i];
          deb_cnt[i] <= `PWS_DEB_W'h0;
        end else begin
          deb_cnt[i] <= deb_cnt[i] + `PWS_DEB_W'h1;
        end
      end
    end
  end

  // Channels that may start a pulse in the present mode
  always_comb begin
    chan_en[0] = 1'b1;
    chan_en[1] = ~mode_single_o;
    chan_en[2] = 1'b1;
  end

  assign fall = filt_q & ~filt_n & chan_en & {3{loaded}};

  // Load done one edge after reset release
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      loaded <= 1'b0;
    end else begin
      loaded <= 1'b1;
    end
  end

  // Mode strap taken on the load edge
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_single_o <= 1'b0;
    end else if (!loaded) begin
      mode_single_o <= down_tied_supply_i;
    end
  end

  // Hold tracking for auto-repeat
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_act <= 1'b0;
      hold_ch <= pws_pkg::PWS_CH_UP;
    end else if (fall != 3'h0) begin
      hold_act <= 1'b1;
      hold_ch <= step_ch;
    end else if (hold_act && filt_n[hold_ch]) begin
      hold_act <= 1'b0;
    end
  end

  // Hold timer: first repeat after the hold span, then at repeat pace
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_cnt <= `PWS_TMR_W'h0;
    end else if (fall != 3'h0) begin
      hold_cnt <= `PWS_TMR_W'(T_HOLD_CYC - 1);
    end else if (rep_fire) begin
      hold_cnt <= `PWS_TMR_W'(T_REPEAT_CYC - 1);
    end else if (hold_act && !filt_n[hold_ch]) begin
      hold_cnt <= hold_cnt - `PWS_TMR_W'h1;
    end
  end

  assign rep_fire = hold_act && !filt_n[hold_ch] &&
                    hold_cnt == `PWS_TMR_W'h0;

  // Step request and the channel behind it
  always_comb begin
    step_go = 1'b0;
    step_ch = pws_pkg::PWS_CH_UP;
    if (fall[0]) begin
      step_go = 1'b1;
    end else if (fall[1]) begin
      step_go = 1'b1;
      step_ch = pws_pkg::PWS_CH_DOWN;
    end else if (fall[2]) begin
      step_go = 1'b1;
      step_ch = pws_pkg::PWS_CH_PROC;
    end else if (rep_fire) begin
      step_go = 1'b1;
      step_ch = hold_ch;
    end
  end

  // Direction of the move and the resulting position
  always_comb begin
    sstyle = step_ch == pws_pkg::PWS_CH_PROC ||
             (step_ch == pws_pkg::PWS_CH_UP && mode_single_o);
    if (sstyle) begin
      eff_up = rev_pend ? ~dir_up_o : dir_up_o;
    end else begin
      eff_up = step_ch == pws_pkg::PWS_CH_UP;
    end
    next_pos = sat_step(wiper_pos_o, eff_up);
  end

  // Activity on the inputs that steer single-style moves
  always_comb begin
    sactive = !filt_n[2];
    if (mode_single_o && !filt_n[0]) begin
      sactive = 1'b1;
    end
  end

  // Idle time on the single-style inputs
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_cnt <= `PWS_TMR_W'h0;
    end else if (sactive) begin
      idle_cnt <= `PWS_TMR_W'h0;
    end else if (idle_cnt < `PWS_TMR_W'(T_IDLE_CYC)) begin
      idle_cnt <= idle_cnt + `PWS_TMR_W'h1;
    end
  end

  assign idle_done = !sactive && idle_cnt == `PWS_TMR_W'(T_IDLE_CYC - 1);

  // Reversal pending after a pause
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rev_pend <= 1'b1;
    end else if (step_go && sstyle) begin
      rev_pend <= 1'b0;
    end else if (idle_done && !end_flip) begin
      rev_pend <= 1'b1;
    end
  end

  // Single-style direction, turned at either end of the range
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dir_up_o <= 1'b0;
      end_flip <= 1'b0;
    end else if (step_go && sstyle) begin
      if (hits_end(next_pos, eff_up)) begin
        dir_up_o <= ~eff_up;
        end_flip <= 1'b1;
      end else begin
        dir_up_o <= eff_up;
        end_flip <= 1'b0;
      end
    end
  end

  // Wiper position
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wiper_pos_o <= `PWS_POS_RST;
    end else if (!loaded) begin
      wiper_pos_o <= nv_pos_i;
    end else if (step_go) begin
      wiper_pos_o <= next_pos;
    end
  end

  // A change arms a save: always before the first save, later only when bit 3 moves
  assign nv_arm = loaded && step_go && next_pos != wiper_pos_o &&
                  (!first_done || next_pos[`PWS_NV_BIT] != stored[`PWS_NV_BIT]);
  assign nv_fire = loaded && !nv_arm && nv_pend && nv_cnt == `PWS_TMR_W'(T_NV_CYC - 1);

  // Save delay timer, restarted by every arming change
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nv_pend <= 1'b0;
      nv_cnt <= `PWS_TMR_W'h0;
    end else if (nv_arm) begin
      nv_pend <= 1'b1;
      nv_cnt <= `PWS_TMR_W'h0;
    end else if (nv_fire) begin
      nv_pend <= 1'b0;
    end else if (nv_pend) begin
      nv_cnt <= nv_cnt + `PWS_TMR_W'h1;
    end
  end

  // One-cycle write strobe
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nv_write_o <= 1'b0;
    end else begin
      nv_write_o <= nv_fire;
    end
  end

  // First save after power-up done
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      first_done <= 1'b0;
    end else if (nv_fire) begin
      first_done <= 1'b1;
    end
  end

  // Last stored position and the data handed to the store
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stored <= `PWS_POS_RST;
      nv_data_o <= `PWS_POS_RST;
    end else if (!loaded) begin
      stored <= nv_pos_i;
      nv_data_o <= nv_pos_i;
    end else if (nv_fire) begin
      stored <= wiper_pos_o;
      nv_data_o <= wiper_pos_o;
    end
  end
endmodule // pws_stepper

// File: dv/pws_stepper_sva.sv
/* Port checker for pws_stepper.
 Bound to every pws_stepper instance. */
`timescale 1ns/1ns
module pws_stepper_sva (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic up_button_input_n_i,
  input wire logic down_button_input_n_i,
  input wire logic proc_pulse_n_i,
  input wire logic [5:0] nv_pos_i,
  input wire logic down_tied_supply_i,
  input wire logic [5:0] wiper_pos_o,
  input wire logic nv_write_o,
  input wire logic [5:0] nv_data_o,
  input wire logic mode_single_o,
  input wire logic dir_up_o
);
  logic [1:0] age;
  // Edges since reset release
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) age <= 2'h0;
    else if (age != 2'h3) age <= age + 2'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  chk_load_state: assert property (age == 2'h1 |-> wiper_pos_o == $past(nv_pos_i)
    && mode_single_o == $past(down_tied_supply_i)) else $error("bad load");
  chk_step_one: assert property (age == 2'h3 && $changed(wiper_pos_o) |->
    ({1'b0, wiper_pos_o} - {1'b0, $past(wiper_pos_o)}) inside {7'h01, 7'h7F})
    else $error("bad step size");
  chk_step_cause: assert property (age == 2'h3 && $changed(wiper_pos_o) |->
    $past(!up_button_input_n_i || !down_button_input_n_i || !proc_pulse_n_i))
    else $error("step without input");
  chk_single_ign: assert property (age == 2'h3 && mode_single_o && $changed(wiper_pos_o)
    |-> $past(!up_button_input_n_i || !proc_pulse_n_i)) else $error("down used");
  chk_dual_up: assert property (age == 2'h3 && !mode_single_o && wiper_pos_o >
    $past(wiper_pos_o) |-> $past(!up_button_input_n_i || !proc_pulse_n_i))
    else $error("bad up");
  chk_dual_down: assert property (age == 2'h3 && !mode_single_o && wiper_pos_o <
    $past(wiper_pos_o) |-> $past(!down_button_input_n_i || !proc_pulse_n_i))
    else $error("bad down");
  chk_mode_hold: assert property (age == 2'h3 |-> $stable(mode_single_o))
    else $error("mode moved");
  chk_write_one: assert property (nv_write_o |=> !nv_write_o)
    else $error("long write");
  chk_write_data: assert property (nv_write_o |-> nv_data_o == $past(wiper_pos_o))
    else $error("bad write data");
  chk_end_turn: assert property (age == 2'h3 && mode_single_o && wiper_pos_o == 6'h3F
    && $changed(wiper_pos_o) |-> ##[0:1] !dir_up_o) else $error("no turn");
endmodule // pws_stepper_sva
bind pws_stepper pws_stepper_sva u_sva (.*);

// File: dv/pws_pulser.sv
/* Pulse source for the three control lines.
 Lines idle high while no low span is left. */
`timescale 1ns/1ns
module pws_pulser (
  input wire logic clk_i,
  input wire logic [2:0] go_i,
  input wire logic [9:0] low_i,
  output logic [2:0] pin_n_o
);
  logic [9:0] left [3] = '{10'h000, 10'h000, 10'h000};
  // Low for a set span, then released
  always @(posedge clk_i) begin
    for (int k = 0; k < 3; k++) begin
      if (go_i[k]) left[k] <= low_i;
      else if (left[k] != 10'h000) left[k] <= left[k] - 10'h001;
    end
  end
  always_comb begin
    for (int k = 0; k < 3; k++) pin_n_o[k] = (left[k] == 10'h000);
  end
endmodule // pws_pulser

// File: dv/testbench.sv
/* Self-checking bench for pws_stepper.
 Uses pws_pulser as the button side. */
`timescale 1ns/1ns
module testbench;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic strap = 1'b0;
  logic [5:0] nv_pos = 6'h00;
  logic [2:0] go = 3'h0;
  logic [9:0] low = 10'h000;
  logic [2:0] pin_n;
  logic [5:0] wiper, nv_data, pos;
  logic nv_write, single;
  int miscompares = 0;
  int checked = 0;
  int writes = 0;
  int seed = 32'h96a8;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) if (nv_write === 1'b1) writes++;
  pws_pulser partner (.clk_i(clk_i), .go_i(go), .low_i(low), .pin_n_o(pin_n));
  pws_stepper #(.T_CONTACT_CYC(8), .T_HOLD_CYC(200), .T_REPEAT_CYC(20), .T_IDLE_CYC(200),
    .T_NV_CYC(100)) uut (.clk_i(clk_i), .nrst_i(nrst_i), .up_button_input_n_i(pin_n[0]),
    .down_button_input_n_i(pin_n[1]), .proc_pulse_n_i(pin_n[2]), .down_tied_supply_i(strap),
    .nv_pos_i(nv_pos), .wiper_pos_o(wiper), .nv_write_o(nv_write), .nv_data_o(nv_data),
    .mode_single_o(single), .dir_up_o());
  function automatic logic [5:0] nxt(input logic [5:0] p, input logic up);
    if (up) return (p == 6'h3F) ? p : p + 6'h01;
    return (p == 6'h00) ? p : p - 6'h01;
  endfunction
  task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic press(input logic [2:0] m, input int len, input int gap);
    @(posedge clk_i);
    go <= m;
    low <= len[9:0];
    @(posedge clk_i);
    go <= 3'h0;
    repeat (len + gap) @(posedge clk_i);
  endtask
  task automatic step(input logic [2:0] m, input logic up);
    press(m, 40, 40);
    pos = nxt(pos, up);
    chk("wiper", pos, wiper);
  endtask
  task automatic rst(input logic s, input logic [5:0] p);
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    strap <= s;
    nv_pos <= p;
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    pos = p;
    writes = 0;
    chk("loaded", p, wiper);
    chk("mode", {5'h00, s}, {5'h00, single});
  endtask
  task automatic complete_run;
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end
  initial begin
    rst(1'b0, 6'h16);
    for (int k = 0; k < 3; k++) begin
      step(3'h1, 1'b1);
      repeat (110) @(posedge clk_i);
      chk("writes", (k == 2) ? 6'h02 : k[5:0] + 6'h01, writes[5:0]);
    end
    chk("nv data", 6'h18, nv_data);
    press(3'h1, 4, 40);
    chk("short", pos, wiper);
    press(3'h1, 20, 3);
    step(3'h1, 1'b1);
    step(3'h2, 1'b0);
    for (int k = 0; k < 8; k++) begin
      logic up;
      up = $random(seed) & 1;
      press(up ? 3'h1 : 3'h2, 30 + ($random(seed) & 63), 40);
      pos = nxt(pos, up);
      chk("random", pos, wiper);
    end
    press(3'h1, 259, 40);
    chk("repeat", pos + 6'h04, wiper);
    rst(1'b0, 6'h3C);
    press(3'h1, 300, 40);
    chk("top", 6'h3F, wiper);
    pos = 6'h3F;
    step(3'h2, 1'b0);
    rst(1'b1, 6'h3E);
    step(3'h1, 1'b1);
    step(3'h1, 1'b0);
    step(3'h1, 1'b0);
    press(3'h2, 40, 40);
    chk("down ignored", pos, wiper);
    repeat (250) @(posedge clk_i);
    step(3'h1, 1'b1);
    step(3'h4, 1'b1);
    complete_run();
  end
endmodule // testbench
